// *** sacc_comm_ctrl.sv ***
// Communications control register and line routing of the sync adapter
`timescale 1ns/10ps
module sacc_comm_ctrl #(
    parameter logic [15:0] base_address = 16'h0300
) (
    // Host bus
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_write,
    input  wire logic        io_read,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_rdata_valid,
    // Board straps and configuration register
    input  wire logic        build_is_dce,
    input  wire logic        driver_jumper,
    input  wire logic        sync_jumper,
    input  wire logic [1:0]  int_source_sel,
    // Test lines
    input  wire logic        test_mode_line_in,
    output logic             test_mode_line_out,
    output logic             test_mode_line_oe_n,
    output logic             local_loop_signal,
    output logic             remote_loop_signal,
    output logic             test_condition_interrupt,
    // Line driver and receiver enables
    output logic             line_receivers_on,
    output logic             line_drivers_on,
    // Connector clock lines
    input  wire logic        returned_rx_clock_line,
    input  wire logic        returned_tx_clock_in,
    output logic             returned_tx_clock_out,
    output logic             returned_tx_clock_oe_n,
    output logic             terminal_tx_clock_out,
    output logic             terminal_tx_clock_oe_n,
    // Serial controller clock pins
    input  wire logic        ctrl_a_clock_in,
    output logic             ctrl_a_clock_out,
    output logic             ctrl_a_clock_oe_n,
    input  wire logic        ctrl_b_clock_pin,
    output logic             ctrl_rx_clock_pin,
    output logic             ctrl_a_sync,
    // Serial controller handshake pins
    input  wire logic        ctrl_a_rts,
    input  wire logic        ctrl_a_dtr,
    input  wire logic        ctrl_b_dtr,
    output logic             ctrl_a_cts,
    output logic             ctrl_a_dcd,
    output logic             ctrl_b_dcd,
    // Connector handshake lines
    input  wire logic [4:0]  hs_in,
    output logic      [4:0]  hs_out,
    output logic      [4:0]  hs_oe_n
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic       dce;
        logic [5:0] ctl;
        logic [7:0] rdata;
        logic       rvalid;
        logic       tm_out;
        logic       tm_oe_n;
        logic       local_loop;
        logic       remote_loop;
        logic       tm_irq;
        logic       rx_on;
        logic       tx_on;
        logic       returned_tx_clock_line_out;
        logic       returned_tx_clock_line_oe_n;
        logic       terminal_tx_clock_line_out;
        logic       terminal_tx_clock_line_oe_n;
        logic       clka_out;
        logic       clka_oe_n;
        logic       rx_clk;
        logic       sync_a;
        logic       a_cts;
        logic       a_dcd;
        logic       b_dcd;
        logic [4:0] hs_out;
        logic [4:0] hs_oe_n;
    } sacc_ctrl_s;

    localparam logic [15:0] REG_ADDR = base_address + sacc_pkg::COMM_OFFSET;

    sacc_ctrl_s                          st;
    sacc_ctrl_s                          next_st;
    logic       [sacc_pkg::PIN_COUNT-1:0] pin_raw;
    logic       [sacc_pkg::PIN_COUNT-1:0] p;
    logic                                reg_hit;
    logic       [7:0]                    status_now;
    logic       [4:0]                    hs_s;

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    assign pin_raw = {hs_in, ctrl_b_dtr, ctrl_a_dtr, ctrl_a_rts,
                      ctrl_b_clock_pin, ctrl_a_clock_in,
                      returned_rx_clock_line, returned_tx_clock_in,
                      test_mode_line_in, sync_jumper, driver_jumper,
                      build_is_dce};

    sacc_sync #(
        .width (sacc_pkg::PIN_COUNT)
    ) u_sync (
        .clk  (clk),
        .din  (pin_raw),
        .dout (p)
    );

    assign hs_s    = p[sacc_pkg::PIN_HS +: 5];
    assign reg_hit = (io_addr == REG_ADDR);

    // Read view: test line on DTE only, reserved bit zero
    assign status_now = {!st.dce && p[sacc_pkg::PIN_TEST],
                         1'b0,
                         st.ctl};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;
        if (reset) begin
            next_st            = '0;
            next_st.dce        = p[sacc_pkg::PIN_BUILD];
            next_st.ctl        = sacc_pkg::CTL_RESET;
            next_st.rdata      = sacc_pkg::RDATA_RESET;
            next_st.tm_oe_n    = 1'b1;
            next_st.returned_tx_clock_line_oe_n = 1'b1;
            next_st.terminal_tx_clock_line_oe_n = 1'b1;
            next_st.clka_oe_n  = 1'b1;
            next_st.hs_oe_n    = sacc_pkg::HS_IDLE;
        end else begin
            // Host access
            if (io_write && reg_hit) begin
                next_st.ctl = io_wdata[5:0];
            end
            if (io_read && reg_hit) begin
                next_st.rdata  = status_now;
                next_st.rvalid = 1'b1;
            end

            // Test lines
            next_st.tm_out      = 1'b0;
            next_st.tm_oe_n     = !st.dce;
            next_st.local_loop  = !st.dce && st.ctl[sacc_pkg::BIT_LOCAL];
            next_st.remote_loop = !st.dce && st.ctl[sacc_pkg::BIT_REMOTE];
            next_st.sync_a      = p[sacc_pkg::PIN_SYNCJ]
                                  && st.ctl[sacc_pkg::BIT_REMOTE];
            next_st.tm_irq      = !st.dce && p[sacc_pkg::PIN_TEST]
                                  && (int_source_sel == sacc_pkg::INT_SRC_TEST);

            // Line enables; jumper high hands them to the register
            next_st.rx_on = !p[sacc_pkg::PIN_DRVJ]
                            || st.ctl[sacc_pkg::BIT_RXEN];
            next_st.tx_on = !p[sacc_pkg::PIN_DRVJ]
                            || st.ctl[sacc_pkg::BIT_TXEN];

            // Receive clock: channel B pin or returned receive line
            if (st.ctl[sacc_pkg::BIT_RXCLK]) begin
                next_st.rx_clk = p[sacc_pkg::PIN_CLKB];
            end else begin
                next_st.rx_clk = p[sacc_pkg::PIN_RETURNED_RX_CLOCK_LINE];
            end
            if (st.dce && st.ctl[sacc_pkg::BIT_RXCLK]) begin
                next_st.returned_tx_clock_line_out  = p[sacc_pkg::PIN_CLKB];
                next_st.returned_tx_clock_line_oe_n = 1'b0;
            end else begin
                next_st.returned_tx_clock_line_out  = 1'b0;
                next_st.returned_tx_clock_line_oe_n = 1'b1;
            end

            // Transmit clock
            next_st.terminal_tx_clock_line_out  = p[sacc_pkg::PIN_CLKA];
            next_st.terminal_tx_clock_line_oe_n = !st.ctl[sacc_pkg::BIT_TXCLK];
            if (!st.dce && !st.ctl[sacc_pkg::BIT_TXCLK]) begin
                next_st.clka_out  = p[sacc_pkg::PIN_RETURNED_TX_CLOCK_LINE];
                next_st.clka_oe_n = 1'b0;
            end else begin
                next_st.clka_out  = 1'b0;
                next_st.clka_oe_n = 1'b1;
            end

            // Handshake routing
            if (st.dce) begin
                next_st.hs_out          = '0;
                next_st.hs_out[sacc_pkg::HS_CTS] = p[sacc_pkg::PIN_RTS_A];
                next_st.hs_out[sacc_pkg::HS_DSR] = p[sacc_pkg::PIN_DTR_A];
                next_st.hs_out[sacc_pkg::HS_CD]  = p[sacc_pkg::PIN_DTR_B];
                next_st.hs_oe_n = ~sacc_pkg::DRIVE_DCE;
                next_st.a_cts   = hs_s[sacc_pkg::HS_RTS];
                next_st.a_dcd   = hs_s[sacc_pkg::HS_DTR];
                next_st.b_dcd   = 1'b0;
            end else begin
                next_st.hs_out          = '0;
                next_st.hs_out[sacc_pkg::HS_RTS] = p[sacc_pkg::PIN_RTS_A];
                next_st.hs_out[sacc_pkg::HS_DTR] = p[sacc_pkg::PIN_DTR_A];
                next_st.hs_oe_n = ~sacc_pkg::DRIVE_DTE;
                next_st.a_cts   = hs_s[sacc_pkg::HS_CTS];
                next_st.a_dcd   = hs_s[sacc_pkg::HS_CD];
                next_st.b_dcd   = hs_s[sacc_pkg::HS_DSR];
            end
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign io_rdata                 = st.rdata;
    assign io_rdata_valid           = st.rvalid;
    assign test_mode_line_out       = st.tm_out;
    assign test_mode_line_oe_n      = st.tm_oe_n;
    assign local_loop_signal        = st.local_loop;
    assign remote_loop_signal       = st.remote_loop;
    assign test_condition_interrupt = st.tm_irq;
    assign line_receivers_on        = st.rx_on;
    assign line_drivers_on          = st.tx_on;
    assign returned_tx_clock_out    = st.returned_tx_clock_line_out;
    assign returned_tx_clock_oe_n   = st.returned_tx_clock_line_oe_n;
    assign terminal_tx_clock_out    = st.terminal_tx_clock_line_out;
    assign terminal_tx_clock_oe_n   = st.terminal_tx_clock_line_oe_n;
    assign ctrl_a_clock_out         = st.clka_out;
    assign ctrl_a_clock_oe_n        = st.clka_oe_n;
    assign ctrl_rx_clock_pin        = st.rx_clk;
    assign ctrl_a_sync              = st.sync_a;
    assign ctrl_a_cts               = st.a_cts;
    assign ctrl_a_dcd               = st.a_dcd;
    assign ctrl_b_dcd               = st.b_dcd;
    assign hs_out                   = st.hs_out;
    assign hs_oe_n                  = st.hs_oe_n;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_reset_clears: assert property (disable iff (1'b0)
        reset |=> st.ctl == sacc_pkg::CTL_RESET && !local_loop_signal)
        else $error("control bits not cleared by reset");

    chk_write_stores: assert property (
        io_write && reg_hit |=> st.ctl == $past(io_wdata[5:0]))
        else $error("write to control register lost");

    chk_read_answer: assert property (
        io_read && reg_hit |=> io_rdata_valid
            && io_rdata[5:0] == $past(st.ctl))
        else $error("read answer missing or wrong");

    chk_read_unmapped: assert property (
        io_read && !reg_hit |=> !io_rdata_valid)
        else $error("answer to unmapped read");

    chk_test_status: assert property (
        io_read && reg_hit |=> io_rdata[7] == $past(status_now[7]))
        else $error("test status bit wrong");

    chk_reserved_zero: assert property (
        io_rdata_valid |-> !io_rdata[6])
        else $error("reserved bit read as one");

    chk_local_loop: assert property (
        io_write && reg_hit && !st.dce |=> ##1
            local_loop_signal == $past(io_wdata[5], 2))
        else $error("local loopback output wrong");

    chk_remote_loop: assert property (
        io_write && reg_hit && !st.dce |=> ##1
            remote_loop_signal == $past(io_wdata[4], 2))
        else $error("remote loopback output wrong");

    chk_sync_route: assert property (
        ctrl_a_sync == ($past(p[sacc_pkg::PIN_SYNCJ]) && $past(st.ctl[4])))
        else $error("sync input not following remote bit");

    chk_dce_rxclk: assert property (
        st.dce && st.ctl[3] |=> !returned_tx_clock_oe_n
            && returned_tx_clock_out == $past(p[sacc_pkg::PIN_CLKB]))
        else $error("DCE receive clock not driven out");

    chk_dte_rx_quiet: assert property (
        !st.dce |=> returned_tx_clock_oe_n)
        else $error("DTE drives receive clock out");

    chk_dte_txclk: assert property (
        !st.dce && st.ctl[2] |=> !terminal_tx_clock_oe_n && ctrl_a_clock_oe_n)
        else $error("DTE transmit clock direction wrong");

    chk_dce_txclk: assert property (
        st.dce |=> ctrl_a_clock_oe_n)
        else $error("DCE takes transmit clock from line");

    chk_line_enables: assert property (
        !$past(reset) |->
        line_receivers_on == (!$past(p[sacc_pkg::PIN_DRVJ]) || $past(st.ctl[1]))
        && line_drivers_on == (!$past(p[sacc_pkg::PIN_DRVJ]) || $past(st.ctl[0])))
        else $error("line enable does not follow jumper and bits");

    chk_dce_no_test: assert property (
        st.dce |=> !local_loop_signal && !remote_loop_signal
            && !test_mode_line_out && !test_mode_line_oe_n)
        else $error("DCE test lines not held off");

    chk_irq_source: assert property (
        test_condition_interrupt |-> $past(int_source_sel) == sacc_pkg::INT_SRC_TEST
            && $past(p[sacc_pkg::PIN_TEST]) && !st.dce)
        else $error("test interrupt without its source");

    chk_dte_handshake: assert property (
        !st.dce |=> hs_oe_n == ~sacc_pkg::DRIVE_DTE
            && ctrl_b_dcd == $past(hs_s[sacc_pkg::HS_DSR]))
        else $error("DTE handshake routing wrong");

    chk_dce_handshake: assert property (
        st.dce |=> hs_oe_n == ~sacc_pkg::DRIVE_DCE
            && hs_out[sacc_pkg::HS_CD] == $past(p[sacc_pkg::PIN_DTR_B]))
        else $error("DCE handshake routing wrong");

    chk_rx_clock_src: assert property (
        !$past(reset) |-> ctrl_rx_clock_pin == ($past(st.ctl[sacc_pkg::BIT_RXCLK])
            ? $past(p[sacc_pkg::PIN_CLKB]) : $past(p[sacc_pkg::PIN_RETURNED_RX_CLOCK_LINE])))
        else $error("receive clock source wrong");

    chk_dte_test_input: assert property (
        !st.dce |=> test_mode_line_oe_n)
        else $error("DTE drives the test line");

    cov_write_read: cover property (
        io_write && reg_hit ##1 io_read && reg_hit ##1 io_rdata_valid);
    cov_test_irq: cover property (test_condition_interrupt);
    cov_dce_rx_drive: cover property (st.dce && !returned_tx_clock_oe_n);
    cov_dte_loop: cover property (!st.dce && remote_loop_signal && ctrl_a_sync);
    cov_dte_tx_in: cover property (!st.dce && !ctrl_a_clock_oe_n);

endmodule // sacc_comm_ctrl

// *** sacc_pkg.sv ***
// Constants for the communications control register of the sync adapter
// How it works
// - 8-bit read/write register at base plus four
// - Bit 7 reads test line on DTE
// - Bit 6 always reads zero
// - Bit 5 drives local loopback on DTE
// - Bit 4 drives remote loopback on DTE
// - Sync jumper routes bit 4 to sync
// - DCE bit 3 selects and drives rx clock
// - DTE never drives receive clock out
// - DTE bit 2 drives or receives tx clock
// - DCE never takes tx clock from connector
// - Bit 1 enables receivers under jumper control
// - Bit 0 enables drivers under jumper control
// - DCE holds test line off, no loopbacks
// - DTE can interrupt on test condition
// - DTE handshake routing through channels A, B
// - DCE handshake routing through channels A, B
// - Channel B receives data and clock
// - Test interrupt only when source selects it
package sacc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] COMM_OFFSET   = 16'h0004;
    localparam logic [5:0]  CTL_RESET     = 6'h00;
    localparam logic [7:0]  RDATA_RESET   = 8'h00;
    localparam int          BIT_TEST      = 7;
    localparam int          BIT_LOCAL     = 5;
    localparam int          BIT_REMOTE    = 4;
    localparam int          BIT_RXCLK     = 3;
    localparam int          BIT_TXCLK     = 2;
    localparam int          BIT_RXEN      = 1;
    localparam int          BIT_TXEN      = 0;
    localparam logic [1:0]  INT_SRC_TEST  = 2'h3;

    // ************************************************************
    // Synchronised pin vector layout
    // ************************************************************
    localparam int PIN_BUILD  = 0;
    localparam int PIN_DRVJ   = 1;
    localparam int PIN_SYNCJ  = 2;
    localparam int PIN_TEST   = 3;
    localparam int PIN_RETURNED_TX_CLOCK_LINE  = 4;
    localparam int PIN_RETURNED_RX_CLOCK_LINE  = 5;
    localparam int PIN_CLKA   = 6;
    localparam int PIN_CLKB   = 7;
    localparam int PIN_RTS_A  = 8;
    localparam int PIN_DTR_A  = 9;
    localparam int PIN_DTR_B  = 10;
    localparam int PIN_HS     = 11;
    localparam int PIN_COUNT  = 16;

    // ************************************************************
    // Connector handshake lines
    // ************************************************************
    localparam int         HS_RTS    = 0;
    localparam int         HS_CTS    = 1;
    localparam int         HS_DSR    = 2;
    localparam int         HS_CD     = 3;
    localparam int         HS_DTR    = 4;
    localparam logic [4:0] DRIVE_DTE = 5'h11;
    localparam logic [4:0] DRIVE_DCE = 5'h0E;
    localparam logic [4:0] HS_IDLE   = 5'h1F;

endpackage

// *** sacc_sync.sv ***
// Two flip-flop synchroniser for board pins
`timescale 1ns/10ps
module sacc_sync #(
    parameter int width = 16
) (
    // Clock
    input  wire logic             clk,
    // Pins and synchronised copy
    input  wire logic [width-1:0] din,
    output logic      [width-1:0] dout
);
    typedef struct packed {
        logic [width-1:0] stage1;
        logic [width-1:0] stage2;
    } sacc_sync_s;

    sacc_sync_s st;
    sacc_sync_s next_st;

    // No reset: the build strap must flow through during reset
    always_comb begin
        next_st.stage1 = din;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign dout = st.stage2;

endmodule // sacc_sync

// *** sacc_far_end.sv ***
// Remote serial equipment model seen through the connector
`timescale 1ns/10ps
module sacc_far_end (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Peer kind and requested line levels
    input  wire logic       peer_is_dte,
    input  wire logic [4:0] hs_level,
    input  wire logic [1:0] clk_level,
    // Loop requests from the card
    input  wire logic       local_req,
    input  wire logic       remote_req,
    // Lines driven by the peer
    output logic            test_line,
    output logic      [4:0] hs_line,
    output logic            rx_clk_line,
    output logic            tx_clk_line
);
    logic [4:0] mask;
    logic       tog;

    // A DTE peer drives RTS and DTR, a DCE peer drives CTS, DSR and CD
    assign mask        = peer_is_dte ? sacc_pkg::DRIVE_DTE : sacc_pkg::DRIVE_DCE;
    // Lines the peer leaves alone toggle so a stale value never passes
    assign hs_line     = (hs_level & mask) | ({5{tog}} & ~mask);
    assign rx_clk_line = clk_level[0];
    assign tx_clk_line = clk_level[1];

    always_ff @(posedge clk) begin
        if (reset) begin
            tog       <= 1'b0;
            test_line <= 1'b0;
        end else begin
            tog       <= ~tog;
            // A DCE peer flags its test condition while a loop is requested
            test_line <= peer_is_dte ? ~test_line : (local_req | remote_req);
        end
    end
endmodule // sacc_far_end

// *** test_sync_adapter_comm_control.sv ***
// Self-checking bench for the communications control register
`timescale 1ns/10ps
module test_sync_adapter_comm_control;
    localparam logic [15:0] BASE     = 16'h0300;
    localparam logic [15:0] REG      = BASE + sacc_pkg::COMM_OFFSET;
    localparam logic [4:0]  DTE_OE_N = ~sacc_pkg::DRIVE_DTE;
    localparam logic [4:0]  DCE_OE_N = ~sacc_pkg::DRIVE_DCE;
    logic        clk, reset, io_write, io_read, io_rdata_valid;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, io_rdata;
    logic [1:0]  int_source_sel, clk_lvl;
    logic        build_is_dce, driver_jumper, sync_jumper, test_mode_line_in;
    logic        test_mode_line_out, test_mode_line_oe_n, test_condition_interrupt;
    logic        local_loop_signal, remote_loop_signal, line_receivers_on, line_drivers_on;
    logic        returned_rx_clock_line, returned_tx_clock_in, returned_tx_clock_out;
    logic        returned_tx_clock_oe_n, terminal_tx_clock_out, terminal_tx_clock_oe_n;
    logic        ctrl_a_clock_in, ctrl_a_clock_out, ctrl_a_clock_oe_n, a_clk_src;
    logic        ctrl_b_clock_pin, ctrl_rx_clock_pin, ctrl_a_sync, far_tm, far_tx;
    logic        ctrl_a_rts, ctrl_a_dtr, ctrl_b_dtr, ctrl_a_cts, ctrl_a_dcd, ctrl_b_dcd;
    logic [4:0]  hs_in, hs_out, hs_oe_n, far_hs, hs_lvl;
    int          n_mismatch, check_count;

    // Shared wires resolve to whichever party drives them
    assign test_mode_line_in    = test_mode_line_oe_n ? far_tm : test_mode_line_out;
    assign returned_tx_clock_in = returned_tx_clock_oe_n ? far_tx : returned_tx_clock_out;
    assign ctrl_a_clock_in      = ctrl_a_clock_oe_n ? a_clk_src : ctrl_a_clock_out;
    assign hs_in                = (hs_out & ~hs_oe_n) | (far_hs & hs_oe_n);

    sacc_comm_ctrl #(.base_address(BASE)) dut_u (
        .clk, .reset, .io_addr, .io_write, .io_read, .io_wdata, .io_rdata,
        .io_rdata_valid, .build_is_dce, .driver_jumper, .sync_jumper,
        .int_source_sel, .test_mode_line_in, .test_mode_line_out,
        .test_mode_line_oe_n, .local_loop_signal, .remote_loop_signal,
        .test_condition_interrupt, .line_receivers_on, .line_drivers_on,
        .returned_rx_clock_line, .returned_tx_clock_in, .returned_tx_clock_out,
        .returned_tx_clock_oe_n, .terminal_tx_clock_out, .terminal_tx_clock_oe_n,
        .ctrl_a_clock_in, .ctrl_a_clock_out, .ctrl_a_clock_oe_n, .ctrl_b_clock_pin,
        .ctrl_rx_clock_pin, .ctrl_a_sync, .ctrl_a_rts, .ctrl_a_dtr, .ctrl_b_dtr,
        .ctrl_a_cts, .ctrl_a_dcd, .ctrl_b_dcd, .hs_in, .hs_out, .hs_oe_n
    );

    sacc_far_end far_u (
        .clk(clk), .reset(reset), .peer_is_dte(build_is_dce), .hs_level(hs_lvl),
        .clk_level(clk_lvl), .local_req(local_loop_signal),
        .remote_req(remote_loop_signal), .test_line(far_tm), .hs_line(far_hs),
        .rx_clk_line(returned_rx_clock_line), .tx_clk_line(far_tx)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict;
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_write <= 1'b1;
        @(posedge clk);
        io_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] e);
        @(posedge clk);
        io_addr <= REG;
        io_read <= 1'b1;
        @(posedge clk);
        io_read <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            #1;
            if (io_rdata_valid === 1'b1)
                break;
            @(posedge clk);
        end
        #1;
        if (io_rdata_valid !== 1'b1) begin
            chk("rdata_valid", 8'h01, io_rdata_valid);
            give_verdict();
        end else begin
            chk("rdata", e, io_rdata);
        end
    endtask

    task automatic rstb(input logic dce);
        @(posedge clk);
        reset        <= 1'b1;
        build_is_dce <= dce;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
    endtask

    task automatic hs_chk(input logic dce);
        logic [4:0] p;
        logic       b;
        for (int k = 0; k < 2; k++) begin
            p = k[0] ? 5'h0A : 5'h15;
            b = k[0];
            @(posedge clk);
            hs_lvl     <= p;
            ctrl_a_rts <= b;
            ctrl_a_dtr <= !b;
            ctrl_b_dtr <= b;
            settle();
            if (dce) begin
                chk("hs_oe_n", DCE_OE_N, hs_oe_n);
                chk("cts", b, hs_out[1]);
                chk("dsr", !b, hs_out[2]);
                chk("cd", b, hs_out[3]);
                chk("a_cts", p[0], ctrl_a_cts);
                chk("a_dcd", p[4], ctrl_a_dcd);
            end else begin
                chk("hs_oe_n", DTE_OE_N, hs_oe_n);
                chk("rts", b, hs_out[0]);
                chk("dtr", !b, hs_out[4]);
                chk("a_cts", p[1], ctrl_a_cts);
                chk("a_dcd", p[3], ctrl_a_dcd);
                chk("b_dcd", p[2], ctrl_b_dcd);
            end
        end
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        n_mismatch = 0;
        check_count = 0;
        reset = 1'b1;
        {io_write, io_read, io_addr, io_wdata, build_is_dce} = '0;
        {driver_jumper, sync_jumper, a_clk_src, ctrl_b_clock_pin} = 4'hF;
        {ctrl_a_rts, ctrl_a_dtr, ctrl_b_dtr, hs_lvl} = '0;
        int_source_sel = sacc_pkg::INT_SRC_TEST;
        clk_lvl = 2'b10;
        rstb(1'b0);
        settle();
        chk("lloop", 8'h00, local_loop_signal);
        chk("rx_on", 8'h00, line_receivers_on);
        rd(8'h00);
        wr(REG, 8'hEF);
        settle();
        rd(8'hAF);
        chk("lloop", 8'h01, local_loop_signal);
        chk("rloop", 8'h00, remote_loop_signal);
        chk("rx_on", 8'h01, line_receivers_on);
        chk("tx_on", 8'h01, line_drivers_on);
        chk("tt_oe_n", 8'h00, terminal_tx_clock_oe_n);
        chk("tt_out", 8'h01, terminal_tx_clock_out);
        chk("a_oe_n", 8'h01, ctrl_a_clock_oe_n);
        chk("rt_oe_n", 8'h01, returned_tx_clock_oe_n);
        chk("rx_clk", 8'h01, ctrl_rx_clock_pin);
        chk("irq", 8'h01, test_condition_interrupt);
        @(posedge clk);
        int_source_sel <= 2'h2;
        settle();
        chk("irq", 8'h00, test_condition_interrupt);
        wr(REG, 8'h10);
        wr(BASE + 16'h0005, 8'h03);
        settle();
        rd(8'h90);
        chk("lloop", 8'h00, local_loop_signal);
        chk("rloop", 8'h01, remote_loop_signal);
        chk("a_sync", 8'h01, ctrl_a_sync);
        chk("rx_on", 8'h00, line_receivers_on);
        chk("tx_on", 8'h00, line_drivers_on);
        chk("tt_oe_n", 8'h01, terminal_tx_clock_oe_n);
        chk("a_oe_n", 8'h00, ctrl_a_clock_oe_n);
        chk("a_out", 8'h01, ctrl_a_clock_out);
        chk("rx_clk", 8'h00, ctrl_rx_clock_pin);
        @(posedge clk);
        sync_jumper   <= 1'b0;
        driver_jumper <= 1'b0;
        clk_lvl       <= 2'b00;
        settle();
        chk("a_sync", 8'h00, ctrl_a_sync);
        chk("rx_on", 8'h01, line_receivers_on);
        chk("tx_on", 8'h01, line_drivers_on);
        chk("a_out", 8'h00, ctrl_a_clock_out);
        hs_chk(1'b0);
        rstb(1'b1);
        settle();
        rd(8'h00);
        wr(REG, 8'h2C);
        settle();
        rd(8'h2C);
        chk("lloop", 8'h00, local_loop_signal);
        chk("tm_out", 8'h00, test_mode_line_out);
        chk("tm_oe_n", 8'h00, test_mode_line_oe_n);
        chk("rt_oe_n", 8'h00, returned_tx_clock_oe_n);
        chk("rt_out", 8'h01, returned_tx_clock_out);
        chk("rx_clk", 8'h01, ctrl_rx_clock_pin);
        chk("tt_oe_n", 8'h00, terminal_tx_clock_oe_n);
        chk("a_oe_n", 8'h01, ctrl_a_clock_oe_n);
        wr(REG, 8'h00);
        settle();
        chk("rt_oe_n", 8'h01, returned_tx_clock_oe_n);
        chk("rx_clk", 8'h00, ctrl_rx_clock_pin);
        chk("tt_oe_n", 8'h01, terminal_tx_clock_oe_n);
        chk("a_oe_n", 8'h01, ctrl_a_clock_oe_n);
        hs_chk(1'b1);
        chk("b_dcd", 8'h00, ctrl_b_dcd);
        give_verdict();
    end
endmodule // test_sync_adapter_comm_control
